// *** rtl/usb_event_pkg.sv ***
package usb_event_pkg;

   // ******************************************************
   // Timing
   // ******************************************************
   localparam int unsigned CLK_FREQ_MHZ = 125;
   localparam real RESUME_TIME_US = 2.5;
   localparam real RESET_TIME_US = 2.5;
   localparam int unsigned IDLE_TIME_MS = 3;
   localparam int unsigned RESUME_CYCLES = int'($ceil(RESUME_TIME_US * CLK_FREQ_MHZ));
   localparam int unsigned RESET_CYCLES = int'($ceil(RESET_TIME_US * CLK_FREQ_MHZ));
   localparam int unsigned IDLE_CYCLES = IDLE_TIME_MS * 1000 * CLK_FREQ_MHZ;
   localparam int unsigned CNT_W = 20;

   // ******************************************************
   // Register map (byte offsets, decoded on haddr[7:0])
   // ******************************************************
   localparam int unsigned OFS_W = 8;
   localparam logic [OFS_W-1:0] OFS_FLAGS = 8'h00;
   localparam logic [OFS_W-1:0] OFS_ERR_ENABLE = 8'h04;
   localparam logic [OFS_W-1:0] OFS_ERR_STATUS = 8'h08;
   localparam logic [OFS_W-1:0] OFS_INT_ENABLE = 8'h0C;
   localparam logic [OFS_W-1:0] OFS_INT_CLEAR = 8'h10;
   localparam logic [OFS_W-1:0] OFS_XFER_STATUS = 8'h14;

   // ******************************************************
   // Flag layout
   // ******************************************************
   localparam int unsigned FLAG_W = 8;
   localparam int unsigned BIT_STALL = 7;
   localparam int unsigned BIT_RESUME = 5;
   localparam int unsigned BIT_IDLE = 4;
   localparam int unsigned BIT_TOKEN = 3;
   localparam int unsigned BIT_SOF = 2;
   localparam int unsigned BIT_ERR = 1;
   localparam int unsigned BIT_RESET = 0;
   localparam logic [FLAG_W-1:0] FLAG_W1C_MASK = 8'hBD;
   localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;
   localparam int unsigned ERR_W = 8;
   localparam logic [ERR_W-1:0] ERR_RESET = 8'h00;
   localparam int unsigned STAT_W = 8;
   localparam int unsigned XFER_COUNT_LSB = 8;
   localparam int unsigned HTRANS_ACTIVE_BIT = 1;

   typedef enum {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_OUT} bus_state_e;

   typedef struct packed {
      logic stall_sent;
      logic token_done;
      logic [STAT_W-1:0] token_status;
      logic sof_rx;
      logic [ERR_W-1:0] error_event;
   } usb_events_s;

endpackage

// *** rtl/usb_device_event_flags.sv ***
// Chosen here: the address map and register access over AHB-Lite.
module usb_device_event_flags
   import usb_event_pkg::*;
#(
   parameter int unsigned IDLE_COUNT = IDLE_CYCLES,
   parameter int unsigned QUEUE_DEPTH = 4
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // USB line state
   input wire logic usb_dp,
   input wire logic usb_dm,
   input wire logic low_speed,
   // Protocol engine events
   input wire usb_events_s usb_events,
   // Interrupt
   output logic irq
);

   localparam int unsigned PTR_W = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
   localparam int unsigned QCNT_W = $clog2(QUEUE_DEPTH + 1);
   localparam logic [QCNT_W-1:0] QUEUE_FULL = QCNT_W'(QUEUE_DEPTH);
   localparam logic [QCNT_W-1:0] QCNT_ONE = QCNT_W'(1);
   localparam logic [CNT_W-1:0] RESUME_TARGET = CNT_W'(RESUME_CYCLES);
   localparam logic [CNT_W-1:0] RESET_TARGET = CNT_W'(RESET_CYCLES);
   localparam logic [CNT_W-1:0] IDLE_TARGET = CNT_W'(IDLE_COUNT);

   // ******************************************************
   // Functions
   // ******************************************************
   // Saturating hold counter: a condition that stays true counts once
   function automatic logic [CNT_W-1:0] hold_count(input logic cond,
                                                   input logic [CNT_W-1:0] cnt,
                                                   input logic [CNT_W-1:0] target);
      logic [CNT_W-1:0] res;
      res = '0;
      if (cond && cnt != target) begin
         res = cnt + 1'b1;
      end else if (cond) begin
         res = cnt;
      end
      return res;
   endfunction

   // One pulse on the cycle that completes the required hold time
   function automatic logic hold_done(input logic cond,
                                      input logic [CNT_W-1:0] cnt,
                                      input logic [CNT_W-1:0] target);
      return cond && (cnt == target - 1'b1);
   endfunction

   function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] ptr);
      logic [PTR_W-1:0] res;
      res = ptr + 1'b1;
      if (ptr == PTR_W'(QUEUE_DEPTH - 1)) begin
         res = '0;
      end
      return res;
   endfunction

   // ******************************************************
   // Bus slave
   // ******************************************************
   bus_state_e state_reg;
   logic [OFS_W-1:0] addr_reg;
   logic addr_phase;
   logic wr_en;
   logic [31:0] read_value;

   assign addr_phase = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
   assign wr_en = (state_reg == BUS_WRITE);
   // Reads take one wait state so that a write just before is always visible
   assign hreadyout = (state_reg != BUS_READ_WAIT);
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= BUS_IDLE;
         addr_reg <= '0;
      end else begin
         case (state_reg)
            BUS_READ_WAIT: begin
               state_reg <= BUS_READ_OUT;
            end
            default: begin
               if (addr_phase) begin
                  state_reg <= hwrite ? BUS_WRITE : BUS_READ_WAIT;
                  addr_reg <= haddr[OFS_W-1:0];
               end else begin
                  state_reg <= BUS_IDLE;
               end
            end
         endcase
      end
   end

   // Read data registered so hrdata stands steady through the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (state_reg == BUS_READ_WAIT) begin
         hrdata <= read_value;
      end
   end

   // ******************************************************
   // Line state detectors
   // ******************************************************
   logic k_state;
   logic j_state;
   logic se0;
   logic [CNT_W-1:0] resume_cnt_reg;
   logic [CNT_W-1:0] reset_cnt_reg;
   logic [CNT_W-1:0] idle_cnt_reg;
   logic resume_evt;
   logic reset_evt;
   logic idle_evt;

   assign k_state = low_speed ? (usb_dp && !usb_dm) : (!usb_dp && usb_dm);
   assign j_state = low_speed ? (!usb_dp && usb_dm) : (usb_dp && !usb_dm);
   assign se0 = !usb_dp && !usb_dm;

   assign resume_evt = hold_done(k_state, resume_cnt_reg, RESUME_TARGET);
   assign idle_evt = hold_done(j_state, idle_cnt_reg, IDLE_TARGET);
   assign reset_evt = hold_done(se0, reset_cnt_reg, RESET_TARGET);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resume_cnt_reg <= '0;
      end else begin
         resume_cnt_reg <= hold_count(k_state, resume_cnt_reg, RESUME_TARGET);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_cnt_reg <= '0;
      end else begin
         idle_cnt_reg <= hold_count(j_state, idle_cnt_reg, IDLE_TARGET);
      end
   end

   // Counter saturates while SE0 lasts, so a reset fires one set only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reset_cnt_reg <= '0;
      end else begin
         reset_cnt_reg <= hold_count(se0, reset_cnt_reg, RESET_TARGET);
      end
   end

   // ******************************************************
   // Error status and summary
   // ******************************************************
   logic [ERR_W-1:0] err_status_reg;
   logic [ERR_W-1:0] err_enable_reg;
   logic [ERR_W-1:0] err_clr;
   logic err_summary;

   assign err_clr = (wr_en && addr_reg == OFS_ERR_STATUS) ? hwdata[ERR_W-1:0] : '0;
   assign err_summary = |(err_status_reg & err_enable_reg);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_status_reg <= ERR_RESET;
      end else begin
         err_status_reg <= (err_status_reg & ~err_clr) | usb_events.error_event;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_enable_reg <= ERR_RESET;
      end else if (wr_en && addr_reg == OFS_ERR_ENABLE) begin
         err_enable_reg <= hwdata[ERR_W-1:0];
      end
   end

   // ******************************************************
   // Transfer status queue
   // ******************************************************
   logic [STAT_W-1:0] queue_mem [QUEUE_DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [QCNT_W-1:0] qcount_reg;
   logic [STAT_W-1:0] queue_head;
   logic push;
   logic pop;
   logic [FLAG_W-1:0] flags_reg;
   logic [FLAG_W-1:0] flag_clr;

   // A completed token with the queue full and no pop in that cycle is dropped; its flag still sets
   assign pop = flag_clr[BIT_TOKEN] && flags_reg[BIT_TOKEN] && qcount_reg != '0;
   assign push = usb_events.token_done && (qcount_reg != QUEUE_FULL || pop);
   assign queue_head = (qcount_reg != '0) ? queue_mem[rd_ptr_reg] : '0;

   always_ff @(posedge hclk) begin
      if (push) begin
         queue_mem[wr_ptr_reg] <= usb_events.token_status;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         qcount_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= next_ptr(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= next_ptr(rd_ptr_reg);
         end
         if (push && !pop) begin
            qcount_reg <= qcount_reg + 1'b1;
         end else if (pop && !push) begin
            qcount_reg <= qcount_reg - 1'b1;
         end
      end
   end

   // ******************************************************
   // Event flags
   // ******************************************************
   logic [FLAG_W-1:0] flag_set;
   logic [FLAG_W-1:0] flags_view;
   logic [FLAG_W-1:0] int_enable_reg;
   logic token_set;

   // Word write of ones clears; a read-modify-write returns all set bits as ones
   assign flag_clr = (wr_en && (addr_reg == OFS_FLAGS || addr_reg == OFS_INT_CLEAR))
                     ? (hwdata[FLAG_W-1:0] & FLAG_W1C_MASK) : '0;
   // Re-raise token-done while further entries wait behind the one popped
   assign token_set = usb_events.token_done || (pop && qcount_reg > QCNT_ONE);

   always_comb begin
      flag_set = '0;
      flag_set[BIT_STALL] = usb_events.stall_sent;
      flag_set[BIT_RESUME] = resume_evt;
      flag_set[BIT_IDLE] = idle_evt;
      flag_set[BIT_TOKEN] = token_set;
      flag_set[BIT_SOF] = usb_events.sof_rx;
      flag_set[BIT_RESET] = reset_evt;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_reg <= FLAG_RESET;
      end else begin
         flags_reg <= ((flags_reg & ~flag_clr) | flag_set) & FLAG_W1C_MASK;
      end
   end

   always_comb begin
      flags_view = flags_reg;
      flags_view[BIT_ERR] = err_summary;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_enable_reg <= FLAG_RESET;
      end else if (wr_en && addr_reg == OFS_INT_ENABLE) begin
         int_enable_reg <= hwdata[FLAG_W-1:0] & (FLAG_W1C_MASK | FLAG_W'(1 << BIT_ERR));
      end
   end

   // Level output: stays high until software clears the flag or its enable
   assign irq = |(flags_view & int_enable_reg);

   // ******************************************************
   // Read mux
   // ******************************************************
   // Unmapped offsets and the write-only clear register read as zero
   always_comb begin
      read_value = '0;
      case (addr_reg)
         OFS_FLAGS: read_value[FLAG_W-1:0] = flags_view;
         OFS_ERR_ENABLE: read_value[ERR_W-1:0] = err_enable_reg;
         OFS_ERR_STATUS: read_value[ERR_W-1:0] = err_status_reg;
         OFS_INT_ENABLE: read_value[FLAG_W-1:0] = int_enable_reg;
         OFS_XFER_STATUS: begin
            read_value[STAT_W-1:0] = queue_head;
            read_value[XFER_COUNT_LSB +: QCNT_W] = qcount_reg;
         end
         default: read_value = '0;
      endcase
   end

endmodule

// *** test/usb_host_model.sv ***
module usb_host_model (
   // Line request: 0 idle J, 1 resume K, 2 bus reset SE0
   input wire logic low_speed,
   input wire logic [1:0] line_req,
   // Bus wires
   output logic usb_dp,
   output logic usb_dm
);
   timeunit 1ns;
   timeprecision 1ps;
   // K drives dp high only at low speed; SE0 pulls both low
   assign usb_dp = (line_req != 2'd2) && ((line_req == 2'd1) == low_speed);
   assign usb_dm = (line_req != 2'd2) && ((line_req == 2'd1) != low_speed);
endmodule

// *** test/usb_device_event_flags_asserts.sv ***
module usb_device_event_flags_asserts
   import usb_event_pkg::*;
#(
   parameter int unsigned IDLE_COUNT = IDLE_CYCLES,
   parameter int unsigned QUEUE_DEPTH = 4
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Line and events
   input wire logic usb_dp,
   input wire logic usb_dm,
   input wire logic low_speed,
   input wire usb_events_s usb_events,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // Line-state counts one below the hold time: the flag sets on that edge
   localparam int RST_N = RESET_CYCLES - 1;
   localparam int RES_N = RESUME_CYCLES - 1;
   localparam int IDLE_N = IDLE_COUNT - 1;
   logic wr_q;
   logic [7:0] a_q, ien, eem;
   logic [9:0] se0_n;
   logic [19:0] j_n, k_n;
   wire se0 = !usb_dp && !usb_dm;
   wire j_st = low_speed ? (!usb_dp && usb_dm) : (usb_dp && !usb_dm);
   wire k_st = low_speed ? (usb_dp && !usb_dm) : (!usb_dp && usb_dm);
   wire take = hsel && htrans[1] && hready;
   // ***************************
   // Shadow of enable registers and line-state counters
   // ***************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         a_q <= 8'h00;
         ien <= 8'h00;
         eem <= 8'h00;
         se0_n <= 10'h000;
         j_n <= 20'h00000;
         k_n <= 20'h00000;
      end else begin
         wr_q <= take && hwrite;
         a_q <= haddr[7:0];
         // Saturates so a long reset cannot wrap and fire twice
         se0_n <= se0 ? se0_n + {9'h000, se0_n != 10'h3FF} : 10'h000;
         j_n <= j_st ? j_n + {19'h00000, j_n != 20'hFFFFF} : 20'h00000;
         k_n <= k_st ? k_n + {19'h00000, k_n != 20'hFFFFF} : 20'h00000;
         if (wr_q && a_q == OFS_INT_ENABLE) ien <= hwdata[7:0] & 8'hBF;
         if (wr_q && a_q == OFS_ERR_ENABLE) eem <= hwdata[7:0];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_read_ans;
      !hreadyout ##1 hreadyout;
   endsequence
   read_wait_a: assert property (take && !hwrite |=> s_read_ans)
      else $error("read answer not after one wait state");
   write_nowait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   flag_zero_a: assert property (
      take && !hwrite && haddr[7:0] == OFS_FLAGS |=> s_read_ans ##0 (hrdata & 32'hFF40) == 0)
      else $error("unimplemented flag bits read nonzero");
   stall_sets_a: assert property (usb_events.stall_sent && ien[7] |=> irq)
      else $error("stall event did not raise irq");
   token_sets_a: assert property (usb_events.token_done && ien[3] |=> irq)
      else $error("token event did not raise irq");
   sof_sets_a: assert property (usb_events.sof_rx && ien[2] |=> irq)
      else $error("frame start did not raise irq");
   resume_flag_a: assert property (k_st && k_n == RES_N && ien[5] |=> irq)
      else $error("resume flag not raised after K hold time");
   idle_flag_a: assert property (j_st && j_n == IDLE_N && ien[4] |=> irq)
      else $error("idle flag not raised after idle hold time");
   bus_reset_a: assert property (se0 && se0_n == RST_N && ien[0] |-> ##[1:4] irq)
      else $error("bus reset flag late");
   masked_err_a: assert property (
      usb_events.error_event != 0 && (usb_events.error_event & eem) == 0 && ien == 8'h02
      && !irq && !wr_q |=> !irq)
      else $error("masked error raised summary");
   irq_masked_a: assert property (ien == 8'h00 |-> !irq)
      else $error("irq high with all sources disabled");
   okay_resp_a: assert property (!hresp)
      else $error("slave response not OKAY");
endmodule

bind usb_device_event_flags usb_device_event_flags_asserts #(.IDLE_COUNT(IDLE_COUNT),
   .QUEUE_DEPTH(QUEUE_DEPTH)) i_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .usb_dp(usb_dp), .usb_dm(usb_dm), .low_speed(low_speed), .usb_events(usb_events),
   .irq(irq));

// *** test/usb_device_event_flags_test.sv ***
module usb_device_event_flags_test;
   import usb_event_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned IDLE_N = 50;
   localparam int LIMIT = 4000;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, low_speed = 1'b0;
   logic rdy_s, irq_s;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_s, q;
   logic [1:0] htrans = 2'b00, line_req = 2'd0;
   usb_events_s ev = '0;
   wire hready, hreadyout, hresp, irq, usb_dp, usb_dm;
   wire [31:0] hrdata;
   int fails = 0, tests_run = 0, cyc = 0;
   assign hready = hreadyout;
   usb_device_event_flags #(.IDLE_COUNT(IDLE_N), .QUEUE_DEPTH(4)) i_usb_device_event_flags (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .usb_dp(usb_dp),
      .usb_dm(usb_dm), .low_speed(low_speed), .usb_events(ev), .irq(irq));
   usb_host_model i_usb_host_model (.low_speed(low_speed), .line_req(line_req),
      .usb_dp(usb_dp), .usb_dm(usb_dm));
   initial begin
      forever #4 hclk = ~hclk;
   end
   // Sampled mid-cycle so the value seen equals the value at the next rising edge
   always @(negedge hclk) begin
      rdy_s = hreadyout;
      rd_s = hrdata;
      irq_s = irq;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         fails++;
         test_done;
      end
   end
   task automatic test_done;
      $display("compared %0d, mismatched %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      q = rd_s;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      check(q, e);
   endtask
   task automatic pulse(input usb_events_s e);
      ev <= e;
      @(posedge hclk);
      ev <= '0;
      // Let an edge pass so a following pulse never reassigns ev in this step
      @(posedge hclk);
   endtask
   task automatic line(input logic [1:0] s, input int n);
      line_req <= s;
      repeat (n) @(posedge hclk);
   endtask
   // ******
   // Tests
   // ******
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(OFS_FLAGS, 32'h0);
      rd(OFS_INT_ENABLE, 32'h0);
      rd(8'h1C, 32'h0);
      check({31'h0, irq_s}, 32'h0);
      repeat (60) @(posedge hclk);
      rd(OFS_FLAGS, 32'h10);
      wr(OFS_FLAGS, 32'hFF);
      rd(OFS_FLAGS, 32'h0);
      $display("test reset_idle finished");
      wr(OFS_INT_ENABLE, 32'hFF);
      rd(OFS_INT_ENABLE, 32'hBF);
      pulse('{stall_sent: 1'b1, default: '0});
      pulse('{sof_rx: 1'b1, default: '0});
      pulse('{token_done: 1'b1, token_status: 8'h5A, default: '0});
      rd(OFS_FLAGS, 32'h8C);
      rd(OFS_XFER_STATUS, 32'h15A);
      check({31'h0, irq_s}, 32'h1);
      wr(OFS_FLAGS, 32'h04);
      rd(OFS_FLAGS, 32'h88);
      pulse('{token_done: 1'b1, token_status: 8'h11, default: '0});
      wr(OFS_FLAGS, 32'h08);
      rd(OFS_FLAGS, 32'h88);
      rd(OFS_XFER_STATUS, 32'h111);
      wr(OFS_FLAGS, 32'h08);
      rd(OFS_XFER_STATUS, 32'h0);
      rd(OFS_FLAGS, 32'h80);
      $display("test event_flags finished");
      // Stall lands on the same edge as the clear-all write
      fork
         begin
            repeat (2) @(posedge hclk);
            ev <= '{stall_sent: 1'b1, default: '0};
            @(posedge hclk);
            ev <= '0;
         end
      join_none
      wr(OFS_FLAGS, 32'hFF);
      rd(OFS_FLAGS, 32'h80);
      // Read-modify-write of bit 2 writes the set stall bit back as a one
      wr(OFS_FLAGS, 32'h84);
      rd(OFS_FLAGS, 32'h0);
      wr(OFS_ERR_ENABLE, 32'h01);
      pulse('{error_event: 8'h01, default: '0});
      rd(OFS_FLAGS, 32'h02);
      wr(OFS_FLAGS, 32'hFF);
      rd(OFS_FLAGS, 32'h02);
      wr(OFS_ERR_STATUS, 32'hFF);
      rd(OFS_FLAGS, 32'h0);
      wr(OFS_INT_ENABLE, 32'h02);
      pulse('{error_event: 8'h02, default: '0});
      rd(OFS_FLAGS, 32'h0);
      check({31'h0, irq_s}, 32'h0);
      wr(OFS_INT_ENABLE, 32'hFF);
      $display("test clear_errors finished");
      line(2'd2, 400);
      rd(OFS_FLAGS, 32'h01);
      wr(OFS_FLAGS, 32'h01);
      line(2'd2, 100);
      rd(OFS_FLAGS, 32'h0);
      line(2'd1, 330);
      rd(OFS_FLAGS, 32'h20);
      wr(OFS_FLAGS, 32'hFF);
      low_speed <= 1'b1;
      line(2'd0, 5);
      line(2'd1, 330);
      rd(OFS_FLAGS, 32'h20);
      line(2'd0, 60);
      rd(OFS_FLAGS, 32'h30);
      $display("test line_states finished");
      test_done;
   end
endmodule
